// *** verification/accum_ctl_properties.sv ***
// port-level assertions for the pulse accumulator control block
`timescale 1ns/1ps
`default_nettype none
module accum_ctl_properties #(
    parameter int COUNT_WIDTH = 16,
    parameter int ADDR_WIDTH  = 10
) (
    // clock and reset
    input wire logic                  core_clk_i,
    input wire logic                  arst_n_i,
    // apb request
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic                  pwrite_i,
    input wire logic [ADDR_WIDTH-1:0] paddr_i,
    input wire logic [31:0]           pwdata_i,
    // timer side and interrupt
    input wire logic                  prescaler_tick_i,
    input wire logic                  counter_clock_tick_o,
    input wire logic                  accum_clock_tick_o,
    input wire logic                  irq_o
);
    localparam logic [ADDR_WIDTH-1:0] A_TSC = ADDR_WIDTH'(10'h018);
    localparam logic [ADDR_WIDTH-1:0] A_CTL = ADDR_WIDTH'(10'h080);
    localparam logic [ADDR_WIDTH-1:0] A_FLG = ADDR_WIDTH'(10'h084);
    localparam logic [ADDR_WIDTH-1:0] A_CNT = ADDR_WIDTH'(10'h088);
    //////////////////////////////////////////////////////////////////////
    // shadow of the control bits, so rules can be judged at the ports
    logic [7:0] ctl;
    logic [1:0] tsc;
    logic       acc;
    logic       on;
    assign acc = psel_i && penable_i;
    assign on  = tsc[0] || ctl[6];
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl <= 8'h00;
            tsc <= 2'h0;
        end else if (acc && pwrite_i && paddr_i == A_CTL) begin
            ctl <= pwdata_i[7:0];
        end else if (acc && pwrite_i && paddr_i == A_TSC) begin
            tsc <= pwdata_i[1:0];
        end
    end
    //////////////////////////////////////////////////////////////////////
    // clock source, gating and flag clearing seen from the pins
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_prescaler_source: assert property (
        (!ctl[6] || ctl[3:2] == 2'b00) |-> counter_clock_tick_o == prescaler_tick_i
    ) else $error("counter clock not from prescaler");
    a_accum_source: assert property (
        ctl[6] && ctl[3:2] == 2'b01 |-> counter_clock_tick_o == accum_clock_tick_o
    ) else $error("counter clock not from accumulator");
    a_gate_timer_off: assert property (
        ctl[6] && ctl[5] && !tsc[0] |-> !accum_clock_tick_o
    ) else $error("gated count with timer stopped");
    a_gate_spacing: assert property (
        ctl[6] && ctl[5] && accum_clock_tick_o |=> (!accum_clock_tick_o || !ctl[5]) [*8]
    ) else $error("gated ticks too close");
    a_irq_masked: assert property (
        ctl[1:0] == 2'b00 |-> !irq_o
    ) else $error("interrupt while both enables clear");
    a_flag_w1c: assert property (
        acc && pwrite_i && paddr_i == A_FLG && pwdata_i[1:0] == 2'b11 && on
        && !accum_clock_tick_o |=> !irq_o
    ) else $error("flags not cleared by ones");
    a_clear_blocked: assert property (
        acc && pwrite_i && paddr_i == A_FLG && !on && irq_o |=> irq_o
    ) else $error("flags cleared with both enables off");
    a_fast_clear: assert property (
        acc && paddr_i == A_CNT && tsc[1] && on && !accum_clock_tick_o |=> !irq_o
    ) else $error("count access did not clear flags");
endmodule
bind pulse_accumulator_control accum_ctl_properties #(
    .COUNT_WIDTH(COUNT_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)
) u_props (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prescaler_tick_i(prescaler_tick_i), .counter_clock_tick_o(counter_clock_tick_o),
    .accum_clock_tick_o(accum_clock_tick_o), .irq_o(irq_o)
);
`default_nettype wire

// *** verification/pin_source.sv ***
// far-side model: the signal source on the channel seven pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    // bench clock, paces the transitions
    input  wire logic core_clk_i,
    // pin level seen by the block
    output var  logic pin_o
);
    // idles high and is always driven, so no floating level appears
    initial pin_o = 1'b1;
    //////////////////////////////////////////////////////////////////////
    // one transition, then hold; a hold of zero clocks is lost
    task automatic drive(input logic lvl, input int hold);
        pin_o <= lvl;
        repeat (hold) @(posedge core_clk_i);
    endtask
endmodule
`default_nettype wire

// *** verification/pulse_accumulator_control_tb.sv ***
// self-checking bench for the pulse accumulator control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
$display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module pulse_accumulator_control_tb;
    localparam logic [9:0] A_TSC = 10'h018;
    localparam logic [9:0] A_CTL = 10'h080;
    localparam logic [9:0] A_FLG = 10'h084;
    localparam logic [9:0] A_CNT = 10'h088;
    // bench-driven inputs
    logic        core_clk_i       = 1'b0;
    logic        arst_n_i         = 1'b0;
    logic        psel_i           = 1'b0;
    logic        penable_i        = 1'b0;
    logic        pwrite_i         = 1'b0;
    logic [9:0]  paddr_i          = 10'h000;
    logic [31:0] pwdata_i         = 32'h0;
    logic        prescaler_tick_i = 1'b0;
    // design outputs and the far-side pin
    wire logic [31:0] prdata_o;
    wire logic        pready_o, pslverr_o, pin, ctick, atick, irq_o;
    // bookkeeping
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [15:0] st;
    logic        e;
    int          n_mismatch = 0, checks_done = 0, n_tick = 0, cycles = 0, n;
    int          seed = 34151;
    pulse_accumulator_control u_dut (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .prescaler_tick_i(prescaler_tick_i),
        .channel_seven_pin_i(pin),
        .counter_clock_tick_o(ctick), .accum_clock_tick_o(atick), .irq_o(irq_o)
    );
    pin_source u_pin (.core_clk_i(core_clk_i), .pin_o(pin));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    //////////////////////////////////////////////////////////////////////
    // verdict; the only place the run ends
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one apb transfer; the expected {error, data} is noted first
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        exp_q.push_back(x);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1) @(posedge core_clk_i);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic reg_wr(input logic [9:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic reg_rd(input logic [9:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, {1'b0, x});
    endtask
    //////////////////////////////////////////////////////////////////////
    // note checker, divided-clock counter, random prescaler, watchdog
    always @(posedge core_clk_i) begin
        prescaler_tick_i <= 1'($random(seed));
        cycles++;
        if (ctick === 1'b1) n_tick++;
        if (psel_i && penable_i && pready_o) begin
            note = exp_q.pop_front();
            `CHK("apb", note, {pslverr_o, prdata_o})
        end
        if (cycles == 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd(A_TSC, 32'h0);
        reg_rd(A_CTL, 32'h0);
        reg_rd(A_FLG, 32'h0);
        reg_rd(A_CNT, 32'h0);
        apb(1'b0, 10'h3fc, 32'h0, {1'b1, 32'h0});
        apb(1'b1, A_CTL + 10'h1, 32'h7f, {1'b1, 32'h0});
        reg_rd(A_CTL, 32'h0);
        // event counting with the timer stopped; one extra active edge
        for (int i = 0; i < 2; i++) begin
            e = 1'(i);
            reg_wr(A_CTL, {24'h0, 3'b010, e, 4'h5});
            u_pin.drive(~e, 4);
            reg_wr(A_CNT, 32'h0);
            reg_wr(A_FLG, 32'h3);
            n = 1 + ($unsigned($random(seed)) % 8);
            repeat (n) begin
                u_pin.drive(e, 4);
                u_pin.drive(~e, 4);
            end
            u_pin.drive(e, 4);
            reg_rd(A_CNT, 32'(n + 1));
            reg_rd(A_FLG, 32'h1);
            `CHK("irq", 1'b1, irq_o)
            reg_wr(A_CTL, {24'h0, 3'b010, e, 4'h4});
            `CHK("irq", 1'b0, irq_o)
        end
        // counter clock from low-byte and full wraps of the count
        for (int i = 2; i < 4; i++) begin
            st = (i == 3) ? 16'hfffe : 16'h00fe;
            reg_wr(A_CTL, {24'h0, 4'h4, 2'(i), 2'b10});
            reg_wr(A_CNT, {16'h0, st});
            reg_wr(A_FLG, 32'h3);
            n_tick = 0;
            repeat (2) begin
                u_pin.drive(1'b0, 4);
                u_pin.drive(1'b1, 4);
            end
            `CHK("ticks", 1, n_tick)
            reg_rd(A_CNT, {16'h0, st + 16'h2});
            reg_rd(A_FLG, {30'h0, i == 3, 1'b1});
            `CHK("irq", i == 3, irq_o)
        end
        // clearing needs an enable; zeros keep, count access clears all
        reg_wr(A_CTL, 32'h0f);
        reg_wr(A_FLG, 32'h3);
        reg_rd(A_FLG, 32'h3);
        reg_wr(A_TSC, 32'h1);
        reg_wr(A_FLG, 32'h1);
        reg_rd(A_FLG, 32'h2);
        reg_wr(A_TSC, 32'h3);
        reg_rd(A_CNT, 32'h0);
        reg_rd(A_FLG, 32'h0);
        // gated time: gate opens first, then the timer runs a fixed span
        reg_wr(A_TSC, 32'h0);
        for (int i = 0; i < 2; i++) begin
            e = 1'(i);
            reg_wr(A_CTL, {24'h0, 3'b011, e, 4'h1});
            u_pin.drive(~e, 4);
            reg_wr(A_CNT, 32'h0);
            reg_wr(A_FLG, 32'h3);
            reg_wr(A_TSC, 32'h1);
            repeat (220) @(posedge core_clk_i);
            reg_wr(A_TSC, 32'h0);
            u_pin.drive(e, 4);
            reg_rd(A_CNT, 32'h3);
            reg_rd(A_FLG, 32'h1);
        end
        end_of_test();
    end
endmodule
`default_nettype wire

// *** verilog/accum_pkg.sv ***
// constants shared by the pulse accumulator control files
package accum_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_TIMER_SYSTEM_CONTROL = 8'h06;
    localparam logic [7:0] IDX_ACCUM_CONTROL        = 8'h20;
    localparam logic [7:0] IDX_ACCUM_FLAGS          = 8'h21;
    localparam logic [7:0] IDX_ACCUM_COUNT          = 8'h22;

    // accumulator_control field positions
    localparam int CTL_SYSTEM_ENABLE = 6;
    localparam int CTL_MODE_SELECT   = 5;
    localparam int CTL_EDGE_CONTROL  = 4;
    localparam int CTL_CLK_SEL_HI    = 3;
    localparam int CTL_CLK_SEL_LO    = 2;
    localparam int CTL_OVF_IRQ_EN    = 1;
    localparam int CTL_EDGE_IRQ_EN   = 0;

    // accumulator_flags field positions, same layout as the enables
    localparam int FLG_OVERFLOW   = 1;
    localparam int FLG_INPUT_EDGE = 0;

    // timer_system_control field positions
    localparam int TSC_TIMER_ENABLE    = 0;
    localparam int TSC_FAST_FLAG_CLEAR = 1;

    // reset values
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [1:0]  FLAGS_RESET   = 2'h0;
    localparam logic [1:0]  TSC_RESET     = 2'h0;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // timing counts
    localparam int GATE_CLOCK_DIVIDE = 64;
    localparam int CLK_DIV_MID_BITS  = 8;   // accum clock / 256
    localparam int SYNC_STAGES       = 2;

    // counter clock source select
    typedef enum logic [1:0] {
        SRC_PRESCALER,
        SRC_ACCUM_CLOCK,
        SRC_ACCUM_DIV_256,
        SRC_ACCUM_DIV_65536
    } clk_src_e;
endpackage

// *** verilog/pin_event_if.sv ***
// synchronised channel pin level and edge strobes
`timescale 1ns/1ps
`default_nettype none
interface pin_event_if;
    logic level;
    logic rise;
    logic fall;
    modport producer (output level, output rise, output fall);
    modport consumer (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** verilog/pin_sync_edge.sv ***
// two-flop synchroniser and edge detector for the channel seven pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
    parameter int STAGES = accum_pkg::SYNC_STAGES
) (
    // clock and reset
    input  wire logic  core_clk_i,
    input  wire logic  arst_n_i,
    // asynchronous pin
    input  wire logic  pin_i,
    // synchronised view
    pin_event_if.producer ev
);
    logic [STAGES-1:0] sync;
    logic              prev;

    if (STAGES < 2) begin : g_stages
        $error("pin_sync_edge needs at least two stages");
    end

    ////////////////////////////////////////////////////////////////////////
    // only the last stage is looked at, the first may be metastable
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync <= '0;
            prev <= 1'b0;
        end else begin
            sync <= {sync[STAGES-2:0], pin_i};
            prev <= sync[STAGES-1];
        end
    end

    // edges compare last stage with its delayed copy
    assign ev.level = sync[STAGES-1];
    assign ev.rise  = sync[STAGES-1] & ~prev;
    assign ev.fall  = ~sync[STAGES-1] & prev;
endmodule
`default_nettype wire

// *** verilog/pulse_accumulator_control.sv ***
// pulse accumulator control, flags, count and counter clock select with apb access
//
// Overview of operation
// - accumulator enable works on its own in event mode, timer enable does not stop event counting
// - accumulator input is the channel seven pin
// - mode bit picks event counting (0) or gated time (1) when enabled
// - event mode counts falling edges for edge control 0, rising for 1
// - gated, edge control 0: pin high gates bus/64, falling end sets flag
// - gated, edge control 1: pin low gates bus/64, rising end sets flag
// - no divide-by-64 clock while timer enable is clear
// - clock select: prescaler, accum clock, accum/256, accum/65536
// - accumulator disabled means counter always uses the prescaler clock
// - clock select change takes effect at once
// - overflow flag raises interrupt only when its enable is set
// - input edge flag raises interrupt only when its enable is set
// - fast flag clear: any aligned count access clears all accumulator flags
// - flags clear only while timer or accumulator enable is set
// - count wrapping from ffff to zero sets the overflow flag
// - counting edge or gate trailing edge sets the input edge flag
// - writing one to a flag clears it, zero leaves it
// - pin is synchronised to bus clock before counting
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pulse_accumulator_control #(
    parameter int COUNT_WIDTH = 16,
    parameter int ADDR_WIDTH  = 10
) (
    // clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   arst_n_i,
    // apb slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [ADDR_WIDTH-1:0]  paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output var  logic [31:0]            prdata_o,
    output logic                        pready_o,
    output var  logic                   pslverr_o,
    // channel pin and timer side
    input  wire logic                   channel_seven_pin_i,
    input  wire logic                   prescaler_tick_i,
    output logic                        counter_clock_tick_o,
    output logic                        accum_clock_tick_o,
    // interrupt
    output logic                        irq_o
);
    localparam int DIV_W = $clog2(accum_pkg::GATE_CLOCK_DIVIDE);

    // parameter checks run at elaboration, so a bad build never starts
    if (COUNT_WIDTH != 16) begin : g_count_width
        $error("accumulator count must be 16 bits");
    end
    if (ADDR_WIDTH < 10) begin : g_addr_width
        $error("address too narrow for the register map");
    end
    // the gate divider wraps by overflow, so its length must be a power of two
    if ((1 << DIV_W) != accum_pkg::GATE_CLOCK_DIVIDE) begin : g_gate_divide
        $error("gate clock divide must be a power of two");
    end
    // the divide-by-256 tap must sit inside the count
    if (accum_pkg::CLK_DIV_MID_BITS >= COUNT_WIDTH) begin : g_mid_tap
        $error("divide-by-256 tap lies outside the count");
    end

    ////////////////////////////////////////////////////////////////////////
    // register state
    // the count is kept here so that a count access can clear flags
    logic [7:0]             accum_control;
    logic [1:0]             accum_flags;
    logic [1:0]             timer_system_control;
    logic [COUNT_WIDTH-1:0] accum_count;
    logic [DIV_W-1:0]       gate_div;

    // control field views
    logic                   accum_system_enable;
    logic                   accum_mode_select;
    logic                   accum_edge_control;
    logic [1:0]             clk_sel;
    logic                   timer_enable;
    logic                   fast_flag_clear;

    assign accum_system_enable = accum_control[accum_pkg::CTL_SYSTEM_ENABLE];
    assign accum_mode_select   = accum_control[accum_pkg::CTL_MODE_SELECT];
    assign accum_edge_control  = accum_control[accum_pkg::CTL_EDGE_CONTROL];
    assign clk_sel             = accum_control[accum_pkg::CTL_CLK_SEL_HI:
                                               accum_pkg::CTL_CLK_SEL_LO];
    assign timer_enable        = timer_system_control[accum_pkg::TSC_TIMER_ENABLE];
    assign fast_flag_clear     = timer_system_control[accum_pkg::TSC_FAST_FLAG_CLEAR];

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    function automatic logic [7:0] reg_index(input logic [ADDR_WIDTH-1:0] addr);
        reg_index = addr[9:2];
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == accum_pkg::IDX_TIMER_SYSTEM_CONTROL) ||
                    (idx == accum_pkg::IDX_ACCUM_CONTROL) ||
                    (idx == accum_pkg::IDX_ACCUM_FLAGS) ||
                    (idx == accum_pkg::IDX_ACCUM_COUNT);
    endfunction

    logic [7:0] idx;
    logic       setup_phase;
    logic       access_done;
    logic       wr_en;
    logic       word_aligned;

    assign idx          = reg_index(paddr_i);
    assign word_aligned = (paddr_i[1:0] == 2'h0);
    assign setup_phase  = psel_i & ~penable_i;
    assign access_done  = psel_i & penable_i;
    // zero wait states, read data was captured in the setup cycle
    assign pready_o     = psel_i & penable_i;
    assign wr_en        = access_done & pwrite_i & word_aligned & is_mapped(idx);

    // one write strobe per register, so the decode is not repeated
    logic ctl_wr;
    logic tsc_wr;
    logic flg_wr;

    assign ctl_wr = wr_en && (idx == accum_pkg::IDX_ACCUM_CONTROL);
    assign tsc_wr = wr_en && (idx == accum_pkg::IDX_TIMER_SYSTEM_CONTROL);
    assign flg_wr = wr_en && (idx == accum_pkg::IDX_ACCUM_FLAGS);

    ////////////////////////////////////////////////////////////////////////
    // synchronised pin (the channel seven pin is the only input)
    // everything past the synchroniser runs on core_clk_i alone
    pin_event_if pin_ev ();

    pin_sync_edge #(
        .STAGES (accum_pkg::SYNC_STAGES)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .pin_i      (channel_seven_pin_i),
        .ev         (pin_ev.producer)
    );

    ////////////////////////////////////////////////////////////////////////
    // divide-by-64 gate clock, stands still while the timer is off
    logic gate_tick;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_div <= '0;
        end else if (!timer_enable) begin
            gate_div <= '0;
        end else begin
            gate_div <= gate_div + 1'b1;
        end
    end

    // restarts from zero at timer enable: the first gated count
    // comes a full 64 clocks later, never after a partial period
    assign gate_tick = timer_enable &&
                       (gate_div == DIV_W'(accum_pkg::GATE_CLOCK_DIVIDE - 1));

    ////////////////////////////////////////////////////////////////////////
    // accumulator clock and edge events
    logic count_event;
    logic gate_open;
    logic gate_trailing;
    logic edge_event;
    logic flag_edge_set;

    // edge control picks polarity in both modes
    assign edge_event    = accum_edge_control ? pin_ev.rise : pin_ev.fall;
    assign gate_open     = accum_edge_control ? ~pin_ev.level : pin_ev.level;
    // trailing edge of gate: falling for high gate, rising for low gate
    assign gate_trailing = accum_edge_control ? pin_ev.rise : pin_ev.fall;

    // the gated flag follows the pin with the timer off too;
    // only the count needs the divided clock
    always_comb begin
        count_event   = 1'b0;
        flag_edge_set = 1'b0;
        if (accum_system_enable) begin
            if (!accum_mode_select) begin
                count_event   = edge_event;
                flag_edge_set = edge_event;
            end else begin
                count_event   = gate_open & gate_tick;
                flag_edge_set = gate_trailing;
            end
        end
    end

    assign accum_clock_tick_o = count_event;

    ////////////////////////////////////////////////////////////////////////
    // accumulator count; a software write wins over a same-cycle increment
    logic count_wrap;
    logic count_low_wrap;
    logic count_wr;

    // wrap decodes use the value before the increment, so they
    // stand in the same cycle as the tick that wraps
    assign count_wr       = wr_en && (idx == accum_pkg::IDX_ACCUM_COUNT);
    assign count_wrap     = count_event && (accum_count == {COUNT_WIDTH{1'b1}});
    assign count_low_wrap = count_event &&
                            (accum_count[accum_pkg::CLK_DIV_MID_BITS-1:0] ==
                             {accum_pkg::CLK_DIV_MID_BITS{1'b1}});

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            accum_count <= accum_pkg::COUNT_RESET;
        end else if (count_wr) begin
            accum_count <= pwdata_i[COUNT_WIDTH-1:0];
        end else if (count_event) begin
            accum_count <= accum_count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter clock select, purely combinational so a new select acts at once
    // a select change in mid-period may give one odd counter period
    accum_pkg::clk_src_e clk_src;

    always_comb begin
        if (!accum_system_enable) begin
            clk_src = accum_pkg::SRC_PRESCALER;
        end else begin
            clk_src = accum_pkg::clk_src_e'(clk_sel);
        end
    end

    always_comb begin
        case (clk_src)
            accum_pkg::SRC_PRESCALER:       counter_clock_tick_o = prescaler_tick_i;
            accum_pkg::SRC_ACCUM_CLOCK:     counter_clock_tick_o = count_event;
            accum_pkg::SRC_ACCUM_DIV_256:   counter_clock_tick_o = count_low_wrap;
            accum_pkg::SRC_ACCUM_DIV_65536: counter_clock_tick_o = count_wrap;
            default:                        counter_clock_tick_o = prescaler_tick_i;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    // a write lands at the access edge and acts in the next cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            accum_control <= accum_pkg::CONTROL_RESET;
        end else if (ctl_wr) begin
            accum_control <= {1'b0, pwdata_i[6:0]}; // bit 7 unused, reads zero
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_system_control <= accum_pkg::TSC_RESET;
        end else if (tsc_wr) begin
            timer_system_control <= pwdata_i[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: hardware set beats any clear in the same cycle
    logic       clear_allowed;
    logic [1:0] flag_clear;
    logic [1:0] flag_set;
    logic       count_access;

    // without either enable the flags are frozen against clearing
    assign clear_allowed = timer_enable | accum_system_enable;
    assign count_access  = access_done && word_aligned &&
                           (idx == accum_pkg::IDX_ACCUM_COUNT);

    // fast clear acts on any aligned count access, read or write
    // a refused clear is dropped, not held for later
    always_comb begin
        flag_clear = 2'h0;
        if (flg_wr) begin
            flag_clear = pwdata_i[1:0];
        end
        if (fast_flag_clear && count_access) begin
            flag_clear = 2'h3;
        end
        if (!clear_allowed) begin
            flag_clear = 2'h0;
        end
    end

    // overflow and edge flags are set by hardware only
    always_comb begin
        flag_set = 2'h0;
        flag_set[accum_pkg::FLG_OVERFLOW]   = count_wrap;
        flag_set[accum_pkg::FLG_INPUT_EDGE] = flag_edge_set;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            accum_flags <= accum_pkg::FLAGS_RESET;
        end else begin
            accum_flags <= flag_set | (accum_flags & ~flag_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt: enables sit at the same bit positions as the flags
    // a level: falls only when the flag or its enable is cleared
    logic [1:0] irq_mask;

    assign irq_mask = {accum_control[accum_pkg::CTL_OVF_IRQ_EN],
                       accum_control[accum_pkg::CTL_EDGE_IRQ_EN]};
    assign irq_o    = |(accum_flags & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read data and error captured in setup, held through the access phase
    logic [31:0] next_prdata;

    // unmapped or unaligned reads give zero, no stale value
    always_comb begin
        case (idx)
            accum_pkg::IDX_TIMER_SYSTEM_CONTROL: next_prdata = {30'h0, timer_system_control};
            accum_pkg::IDX_ACCUM_CONTROL:        next_prdata = {24'h0, accum_control};
            accum_pkg::IDX_ACCUM_FLAGS:          next_prdata = {30'h0, accum_flags};
            accum_pkg::IDX_ACCUM_COUNT:          next_prdata = {16'h0, accum_count};
            default:                             next_prdata = 32'h0;
        endcase
    end

    // read data captured in setup, held through the access phase
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= 32'h0;
        end else if (setup_phase) begin
            prdata_o <= (!pwrite_i && word_aligned) ? next_prdata : 32'h0;
        end
    end

    // error flag captured with the read data, so both stand together
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pslverr_o <= 1'b0;
        end else if (setup_phase) begin
            pslverr_o <= !(word_aligned && is_mapped(idx));
        end
    end
endmodule
`default_nettype wire
